/* bench/slave_port_model.sv */
// Purpose: Slave serial port at the far end of the link.
// Assumes: Bench sets direction and word size as the slave's software would.
// Notes:   Behavioural; the bench drains the two-word receive store.
`default_nettype none
module slave_port_model (
	input  wire logic ref_clk,
	input  wire logic clk_line,
	input  wire logic dt_line,
	input  wire logic transmit_mode,
	input  wire logic nine,
	output logic      dt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] transmit_fifo [$];
	logic [8:0] receive_fifo [$];
	logic [8:0] transmit_shift_register;
	logic [8:0] receive_shift_register;
	int         tbit = 0;
	int         rbit = 0;
	int         lead_edges = 0;
	int         high_len = 0;
	int         hi_cnt = 0;
	logic       in_frame = 1'b0;
	logic       overrun_error_flag = 1'b0;
	logic       receive_interrupt_flag = 1'b0;
	logic       transmit_interrupt_flag = 1'b0;
	initial dt_out = 1'b0;
	always @(posedge clk_line) begin
		lead_edges++;
		if (transmit_mode) begin
			if (tbit == 0) begin
				transmit_shift_register = (transmit_fifo.size() > 0) ? transmit_fifo.pop_front() : 9'h000;
				transmit_interrupt_flag = (transmit_fifo.size() == 0);
			end
			in_frame = 1'b1;
			dt_out <= transmit_shift_register[tbit];
			tbit = (tbit == (nine ? 8 : 7)) ? 0 : tbit + 1;
		end
	end
	always @(negedge clk_line) begin
		if (!transmit_mode) begin
			receive_shift_register[rbit] = dt_line;
			rbit++;
			if (rbit == (nine ? 9 : 8)) begin
				rbit = 0;
				if (!nine) receive_shift_register[8] = 1'b0;
				if (receive_fifo.size() < 2 && !overrun_error_flag) begin
					receive_fifo.push_back(receive_shift_register);
					receive_interrupt_flag = 1'b1;
				end else overrun_error_flag = 1'b1;
			end
		end else if (tbit == 0) in_frame = 1'b0;
	end
	// Released line shows a changing pattern, so no stale bit can pass
	always @(negedge ref_clk) if (!in_frame) dt_out <= ~dt_out;
	always @(posedge ref_clk) begin
		if (clk_line) hi_cnt++;
		else if (hi_cnt != 0) begin
			high_len = hi_cnt;
			hi_cnt = 0;
		end
	end
endmodule
`default_nettype wire

/* bench/sync_link_master_tb.sv */
// Purpose: Self-checking bench for the link master against a slave model.
// Assumes: Register map and timing as in the shared package.
// Notes:   Reads are checked one cycle after the strobe, link words as they land.
`default_nettype none
module sync_link_master_tb
	import sync_link_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              ref_clk = 1'b0;
	logic              rstn = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic              clock_pin_o;
	logic              clock_pin_oe;
	logic              data_pin_o;
	logic              data_pin_oe;
	logic              dt_out;
	logic              transmit_mode = 1'b0;
	logic              nine = 1'b0;
	logic              pend = 1'b0;
	logic [7:0]        s = 8'h17;
	logic [7:0]        rx_w [3];
	logic [15:0]       rd_q [$];
	logic [8:0]        word_q [$];
	logic [15:0]       note;
	int                fail_count = 0;
	int                samples_checked = 0;
	int                cycles = 0;
	// Clock line assumed pulled low while released
	wire logic         clk_line = clock_pin_oe ? clock_pin_o : 1'b0;
	wire logic         dt_line = data_pin_oe ? data_pin_o : dt_out;

	sync_link_master u_sync_link_master (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .clock_pin_o(clock_pin_o),
		.clock_pin_oe(clock_pin_oe), .data_pin_i(dt_line), .data_pin_o(data_pin_o),
		.data_pin_oe(data_pin_oe));
	slave_port_model u_slave_port_model (.ref_clk(ref_clk), .clk_line(clk_line),
		.dt_line(dt_line), .transmit_mode(transmit_mode), .nine(nine), .dt_out(dt_out));

	always #4 ref_clk = ~ref_clk;

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic bus(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic w, input logic r);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= r;
		@(posedge ref_clk);
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
		rd_q.push_back({e, m});
		bus(a, 8'h00, 1'b0, 1'b1);
	endtask
	task automatic wait_edges(input int n);
		bus('0, 8'h00, 1'b0, 1'b0);
		for (int i = 0; i < 4000 && u_slave_port_model.lead_edges < n; i++) @(posedge ref_clk);
		repeat (40) @(posedge ref_clk);
	endtask

	always @(posedge ref_clk) begin
		if (pend) begin
			note = rd_q.pop_front();
			check("register read", {8'h00, rdata & note[7:0]}, {8'h00, note[15:8] & note[7:0]});
		end
		pend <= rd;
		if (u_slave_port_model.receive_fifo.size() > 0)
			check("link word", 16'(u_slave_port_model.receive_fifo.pop_front()), 16'(word_q.pop_front()));
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			test_done();
		end
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		rd_chk(REG_CTRL, CTRL_RESET, 8'hFF);
		rd_chk(REG_HALF, HALF_RESET, 8'hFF);
		rd_chk(REG_STATUS, 8'h02, 8'h0F);
		rd_chk(3'h7, 8'h00, 8'hFF);
		rd_chk(REG_RXDATA, 8'h00, 8'hFF);
		bus(REG_HALF, HALF_FLOOR, 1'b1, 1'b0);
		rd_chk(REG_HALF, HALF_FLOOR, 8'hFF);
		bus(REG_CTRL, 8'h01, 1'b1, 1'b0);
		for (int i = 0; i < 2; i++) begin
			s = lfsr(s);
			word_q.push_back({1'b0, s});
			bus(REG_TXDATA, s, 1'b1, 1'b0);
		end
		rd_chk(REG_STATUS, 8'h03, 8'h03);
		wait_edges(16);
		check("clock edges", 16'(u_slave_port_model.lead_edges), 16'h0010);
		check("rx flag", 16'(u_slave_port_model.receive_interrupt_flag), 16'h0001);
		check("high phase", 16'(u_slave_port_model.high_len), 16'(HALF_FLOOR));
		nine <= 1'b1;
		bus(REG_CTRL, 8'h0D, 1'b1, 1'b0);
		s = lfsr(s);
		word_q.push_back({1'b1, s});
		bus(REG_TXDATA, s, 1'b1, 1'b0);
		wait_edges(25);
		check("nine bit edges", 16'(u_slave_port_model.lead_edges), 16'h0019);
		bus(REG_HALF, HALF_RESET, 1'b1, 1'b0);
		nine <= 1'b0;
		transmit_mode <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			s = lfsr(s);
			rx_w[i] = s;
			u_slave_port_model.transmit_fifo.push_back({1'b0, s});
		end
		bus(REG_CTRL, 8'h03, 1'b1, 1'b0);
		bus(REG_RXCOUNT, 8'h03, 1'b1, 1'b0);
		wait_edges(41);
		repeat (300) @(posedge ref_clk);
		check("stalled edges", 16'(u_slave_port_model.lead_edges), 16'h0029);
		check("tx flag held", 16'(u_slave_port_model.transmit_interrupt_flag), 16'h0000);
		rd_chk(REG_STATUS, 8'h04, 8'h04);
		rd_chk(REG_RXDATA, rx_w[0], 8'hFF);
		rd_chk(REG_RXDATA, rx_w[1], 8'hFF);
		wait_edges(49);
		check("tx flag set", 16'(u_slave_port_model.transmit_interrupt_flag), 16'h0001);
		rd_chk(REG_RXDATA, rx_w[2], 8'hFF);
		rd_chk(REG_RXDATA, 8'h00, 8'hFF);
		nine <= 1'b1;
		s = lfsr(s);
		u_slave_port_model.transmit_fifo.push_back({1'b1, s});
		bus(REG_CTRL, 8'h07, 1'b1, 1'b0);
		bus(REG_RXCOUNT, 8'h01, 1'b1, 1'b0);
		wait_edges(58);
		rd_chk(REG_STATUS, 8'h08, 8'h08);
		rd_chk(REG_RXDATA, s, 8'hFF);
		transmit_mode <= 1'b0;
		nine <= 1'b0;
		bus(REG_CTRL, 8'h01, 1'b1, 1'b0);
		bus(REG_TXDATA, lfsr(s), 1'b1, 1'b0);
		bus('0, 8'h00, 1'b0, 1'b0);
		repeat (20) @(posedge ref_clk);
		bus(REG_CTRL, 8'h00, 1'b1, 1'b0);
		bus('0, 8'h00, 1'b0, 1'b0);
		repeat (2) @(posedge ref_clk);
		#1;
		check("aborted link", {13'h0000, data_pin_oe, clock_pin_oe, clock_pin_o}, 16'h0000);
		test_done();
	end
endmodule
`default_nettype wire

/* shared/sync_link_pkg.sv */
// Purpose: Constants for the synchronous serial link master.
// Assumes: ref_clk at 125 MHz; registers are 8 bits wide.
// Notes:   Register map and field positions of the controller.
`default_nettype none
package sync_link_pkg;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned HALF_MIN_NS   = 32;
	localparam int unsigned HALF_DEF_NS   = 64;
	localparam int unsigned HALF_MIN_CYC  = (HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HALF_DEF_CYC  = HALF_DEF_NS / CLK_PERIOD_NS;

	localparam int unsigned ADDR_W  = 3;
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned WORD_W  = 9;
	localparam int unsigned BITS_W  = 4;

	localparam logic [ADDR_W-1:0] REG_CTRL    = 3'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 3'h1;
	localparam logic [ADDR_W-1:0] REG_TXDATA  = 3'h2;
	localparam logic [ADDR_W-1:0] REG_RXDATA  = 3'h3;
	localparam logic [ADDR_W-1:0] REG_RXCOUNT = 3'h4;
	localparam logic [ADDR_W-1:0] REG_HALF    = 3'h5;

	localparam int unsigned CTRL_EN   = 0;
	localparam int unsigned CTRL_RECV = 1;
	localparam int unsigned CTRL_NINE = 2;
	localparam int unsigned CTRL_TX9  = 3;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

	localparam int unsigned ST_BUSY     = 0;
	localparam int unsigned ST_TX_READY = 1;
	localparam int unsigned ST_RX_VALID = 2;
	localparam int unsigned ST_RX9      = 3;

	localparam logic [DATA_W-1:0] HALF_RESET = 8'(HALF_DEF_CYC);
	localparam logic [DATA_W-1:0] HALF_FLOOR = 8'(HALF_MIN_CYC);
	localparam logic [BITS_W-1:0] BITS_EIGHT = 4'h8;
	localparam logic [BITS_W-1:0] BITS_NINE  = 4'h9;
endpackage
`default_nettype wire

/* verilog/pair_buffer.sv */
// Purpose: Two-entry word buffer with valid/ready on both sides.
// Assumes: Single clock domain.
// Notes:   Full shows as in_ready low; a push while full is dropped.
`default_nettype none
module pair_buffer #(
	parameter int unsigned W = 9
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic      [W-1:0] out_data,
	input  wire logic         out_ready
);
	logic [W-1:0] mem [2];
	logic         wr_ptr;
	logic         rd_ptr;
	logic [1:0]   count;
	logic         push;
	logic         pop;

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mem[0] <= '0;
			mem[1] <= '0;
		end else if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push && !pop)
				count <= count + 2'h1;
			else if (pop && !push)
				count <= count - 2'h1;
		end
	end
endmodule
`default_nettype wire

/* verilog/sync_link_master.sv */
// Purpose: Master end of a synchronous serial link to a slave port.
// Assumes: ref_clk 125 MHz; the slave is set up for slave mode by its software.
// Notes:   Makes the link clock by a divider; idle low, leading edge rising.
// Operation
// - Slave takes its shift clock from outside; this end makes it.
// - Slave pins are inputs; only this end drives the clock line.
// - Slave transmits only with both receive enables clear; direction chosen here.
// - Interrupt-driven slave transmit needs global, peripheral, transmit enables set.
// - Nine-bit transmit: ninth bit set first, nine bits shift per word.
// - Slave transmit enable set; a low-byte write starts the transfer.
// - Slave enables continuous receive after configuring everything else.
// - Nine-bit receive: ninth bit fetched apart from the low byte.
// - Reading receive data returns oldest word low byte and advances.
// - Overrun cleared by clearing continuous receive or the port enable.
// - Master gives exactly one clock cycle per data bit.
// - Data changes on leading clock edge, sampled on trailing edge.
//
// The strobed register port and the register addresses were decided locally.
`default_nettype none
module sync_link_master
	import sync_link_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [DATA_W-1:0] rdata,
	output logic                   clock_pin_o,
	output logic                   clock_pin_oe,
	input  wire logic              data_pin_i,
	output logic                   data_pin_o,
	output logic                   data_pin_oe
);
	typedef enum logic [1:0] {st_idle, st_high, st_low} link_state_t;

	link_state_t       state;
	logic [DATA_W-1:0] ctrl;
	logic [DATA_W-1:0] half_cfg;
	logic [DATA_W-1:0] half_eff;
	logic [DATA_W-1:0] rx_todo;
	logic [DATA_W-1:0] cnt;
	logic [BITS_W-1:0] bits_left;
	logic [WORD_W-1:0] shift;
	logic              frame_recv;
	logic              frame_nine;
	logic              dt_s1;
	logic              dt_s2;
	logic              dt_s3;
	logic              dt_filt;
	logic              half_done;
	logic              start_tx;
	logic              start_rx;
	logic              trail;
	logic              lead_next;
	logic              frame_end;
	logic              tx_in_ready;
	logic              tx_out_valid;
	logic [WORD_W-1:0] tx_out_data;
	logic              rx_in_ready;
	logic              rx_out_valid;
	logic [WORD_W-1:0] rx_out_data;
	logic [WORD_W-1:0] rx_word;
	logic              rx_pop;
	logic [BITS_W-1:0] lead_cnt;

	// Data pin from the slave crosses into ref_clk; first flop feeds only the second
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dt_s1   <= 1'b0;
			dt_s2   <= 1'b0;
			dt_s3   <= 1'b0;
			dt_filt <= 1'b0;
		end else begin
			dt_s1 <= data_pin_i;
			dt_s2 <= dt_s1;
			dt_s3 <= dt_s2;
			if (dt_s2 == dt_s3)
				dt_filt <= dt_s3;
		end
	end

	// Too short a half period would outrun the slave's own pin sampling
	assign half_eff  = (half_cfg < HALF_FLOOR) ? HALF_FLOOR : half_cfg;
	assign half_done = (cnt == 8'h00);
	// Clearing the enable aborts a frame, which also lets the slave's overrun be cleared
	assign start_tx  = (state == st_idle) && ctrl[CTRL_EN] && !ctrl[CTRL_RECV]
		&& tx_out_valid;
	assign start_rx  = (state == st_idle) && ctrl[CTRL_EN] && ctrl[CTRL_RECV]
		&& (rx_todo != 8'h00) && rx_in_ready;
	assign trail     = (state == st_high) && half_done;
	assign lead_next = (state == st_low) && half_done && (bits_left != 4'h0);
	assign frame_end = (state == st_low) && half_done && (bits_left == 4'h0);
	assign rx_pop    = rd && (addr == REG_RXDATA) && rx_out_valid;
	// Eight-bit words sit one place high after eight shifts
	assign rx_word   = frame_nine ? shift : {1'b0, shift[WORD_W-1:1]};

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state     <= st_idle;
			cnt       <= 8'h00;
			bits_left <= 4'h0;
			clock_pin_o <= 1'b0;
		end else if (!ctrl[CTRL_EN]) begin
			state       <= st_idle;
			clock_pin_o <= 1'b0;
		end else begin
			unique case (state)
				st_idle: begin
					if (start_tx || start_rx) begin
						state       <= st_high;
						clock_pin_o <= 1'b1;
						cnt         <= half_eff - 8'h01;
						bits_left   <= (ctrl[CTRL_NINE] ? BITS_NINE : BITS_EIGHT) - 4'h1;
					end
				end
				st_high: begin
					if (half_done) begin
						state       <= st_low;
						clock_pin_o <= 1'b0;
						cnt         <= half_eff - 8'h01;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				st_low: begin
					if (frame_end) begin
						state <= st_idle;
					end else if (lead_next) begin
						state       <= st_high;
						clock_pin_o <= 1'b1;
						cnt         <= half_eff - 8'h01;
						bits_left   <= bits_left - 4'h1;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shift      <= '0;
			frame_recv <= 1'b0;
			frame_nine <= 1'b0;
		end else if (start_tx) begin
			shift      <= tx_out_data;
			frame_recv <= 1'b0;
			frame_nine <= ctrl[CTRL_NINE];
		end else if (start_rx) begin
			shift      <= '0;
			frame_recv <= 1'b1;
			frame_nine <= ctrl[CTRL_NINE];
		end else if (trail && frame_recv) begin
			shift <= {dt_filt, shift[WORD_W-1:1]};
		end else if (lead_next && !frame_recv) begin
			shift <= {1'b0, shift[WORD_W-1:1]};
		end
	end

	// Each new bit goes out together with the rising clock, LSB first
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			data_pin_o <= 1'b0;
		else if (start_tx)
			data_pin_o <= tx_out_data[0];
		else if (lead_next && !frame_recv)
			data_pin_o <= shift[1];
	end

	assign clock_pin_oe = ctrl[CTRL_EN];
	assign data_pin_oe  = (state != st_idle) && !frame_recv;

	pair_buffer #(
		.W(WORD_W)
	) tx_buf (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (wr && (addr == REG_TXDATA)),
		.in_data   ({ctrl[CTRL_TX9], wdata}),
		.in_ready  (tx_in_ready),
		.out_valid (tx_out_valid),
		.out_data  (tx_out_data),
		.out_ready (start_tx)
	);

	pair_buffer #(
		.W(WORD_W)
	) rx_buf (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (frame_end && frame_recv),
		.in_data   (rx_word),
		.in_ready  (rx_in_ready),
		.out_valid (rx_out_valid),
		.out_data  (rx_out_data),
		.out_ready (rx_pop)
	);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl     <= CTRL_RESET;
			half_cfg <= HALF_RESET;
		end else if (wr) begin
			if (addr == REG_CTRL)
				ctrl <= wdata;
			if (addr == REG_HALF)
				half_cfg <= wdata;
		end
	end

	// A new count overrides the word that starts in the same cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			rx_todo <= 8'h00;
		else if (wr && (addr == REG_RXCOUNT))
			rx_todo <= wdata;
		else if (start_rx)
			rx_todo <= rx_todo - 8'h01;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				REG_CTRL:    rdata <= ctrl;
				REG_STATUS:  rdata <= {4'h0, rx_out_data[WORD_W-1] && rx_out_valid,
					rx_out_valid, tx_in_ready, state != st_idle};
				REG_TXDATA:  rdata <= 8'h00;
				REG_RXDATA:  rdata <= rx_out_valid ? rx_out_data[DATA_W-1:0] : 8'h00;
				REG_RXCOUNT: rdata <= rx_todo;
				REG_HALF:    rdata <= half_cfg;
				default:     rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// Counts rising clock edges in a frame for the checks below
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			lead_cnt <= 4'h0;
		else if (start_tx || start_rx)
			lead_cnt <= 4'h1;
		else if (lead_next)
			lead_cnt <= lead_cnt + 4'h1;
	end

	property p_clk_idle_low;
		@(posedge ref_clk) disable iff (!rstn)
		(state == st_idle) |-> !clock_pin_o;
	endproperty
	a_clk_idle_low: assert property (p_clk_idle_low) else $error("clock high while idle");

	property p_eight_bits;
		@(posedge ref_clk) disable iff (!rstn)
		(frame_end && !frame_nine) |-> (lead_cnt == 4'h8);
	endproperty
	a_eight_bits: assert property (p_eight_bits) else $error("8-bit frame edge count");

	property p_nine_bits;
		@(posedge ref_clk) disable iff (!rstn)
		(frame_end && frame_nine) |-> (lead_cnt == 4'h9);
	endproperty
	a_nine_bits: assert property (p_nine_bits) else $error("9-bit frame edge count");

	property p_high_width;
		@(posedge ref_clk) disable iff (!rstn)
		$rose(clock_pin_o) |-> (clock_pin_o || !ctrl[CTRL_EN]) [*4];
	endproperty
	a_high_width: assert property (p_high_width) else $error("clock high too short");

	property p_data_steady;
		@(posedge ref_clk) disable iff (!rstn)
		(data_pin_oe && clock_pin_o && $past(clock_pin_o)) |-> $stable(data_pin_o);
	endproperty
	a_data_steady: assert property (p_data_steady) else $error("data moved mid-high");

	property p_tx_start;
		@(posedge ref_clk) disable iff (!rstn)
		(state == st_idle && ctrl[CTRL_EN] && !ctrl[CTRL_RECV] && tx_out_valid)
		|=> (clock_pin_o && data_pin_oe);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("queued word not started");

	property p_rx_read;
		@(posedge ref_clk) disable iff (!rstn)
		rx_pop |=> (rdata == $past(rx_out_data[DATA_W-1:0]));
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("receive read wrong word");

	property p_rx_ninth;
		@(posedge ref_clk) disable iff (!rstn)
		(rd && addr == REG_STATUS && rx_out_valid)
		|=> (rdata[ST_RX9] == $past(rx_out_data[WORD_W-1]));
	endproperty
	a_rx_ninth: assert property (p_rx_ninth) else $error("ninth bit status wrong");

	property p_no_drive_recv;
		@(posedge ref_clk) disable iff (!rstn)
		(state == st_idle) && ctrl[CTRL_EN] && ctrl[CTRL_RECV] && (rx_todo != 8'h00)
		&& rx_in_ready |=> clock_pin_o && !data_pin_oe;
	endproperty
	a_no_drive_recv: assert property (p_no_drive_recv) else $error("drove data in receive");

	// A full receive buffer must hold the clock still, or the received word is dropped
	property p_rx_stall;
		@(posedge ref_clk) disable iff (!rstn)
		(state == st_idle) && ctrl[CTRL_RECV] && !rx_in_ready |=> !clock_pin_o;
	endproperty
	a_rx_stall: assert property (p_rx_stall) else $error("clocked into full buffer");

	c_tx_frame: cover property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && !frame_recv);
	c_rx_frame: cover property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_recv && frame_nine);
	c_rx_full: cover property (@(posedge ref_clk) disable iff (!rstn)
		!rx_in_ready && ctrl[CTRL_RECV] && (rx_todo != 8'h00));
	c_tx_full: cover property (@(posedge ref_clk) disable iff (!rstn) !tx_in_ready);
endmodule
`default_nettype wire
